// file: logic/timing_mgmt_rtp_framer.sv
// Timing and management payload framer into RTP packets
// Function
// - Every packet goes to the fixed multicast group and port plus channel offset.
// - Structure larger than the MTU is split; each packet with headers fits.
// - Marker is one on the first packet of a set, zero on the rest.
// - All packets of one set carry the same timestamp.
// - Timestamp is 22 low seconds bits then nanoseconds bits 29 to 20.
// - Padding bit is always zero.
// - Extension bit is one exactly when a signing extension is present.
// - Signed packets carry the extension word right after the source identifier.
// - Contributing-source count is zero and no such words are sent.
// - Payload type is 76 in every packet.
// - Sequence number advances by one per packet sent.
// - Synchronization source identifier is zero.
// - Structure header first part packed MSB-first with the listed widths.
// - Header continues with the remaining fields and six reserved one bits.
// - Emission time pairs then station entries with 29 reserved one bits follow.
// - Release time with reserved 11, then a 16-bit check word close it.
// - Length field holds the byte count of the whole structure.
// - Major version field is zero.
// - Minor version field is zero.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tmf_consts.svh"
module timing_mgmt_rtp_framer
    import tmf_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           resetn,
    // Register port
    input  wire logic [3:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [31:0]         reg_rdata,
    // Frame request
    input  wire logic           frame_start,
    input  wire frame_cfg_t     frame_cfg,
    output logic                frame_ready,
    // Table load
    input  wire logic           time_wr,
    input  wire logic [5:0]     time_idx,
    input  wire emission_time_t time_data,
    input  wire logic           stn_wr,
    input  wire logic [5:0]     stn_idx,
    input  wire station_entry_t stn_data,
    // Packet byte stream
    output logic                out_valid,
    output logic [7:0]          out_data,
    output logic                out_last,
    output pkt_info_t           out_info,
    input  wire logic           out_ready
);

    function automatic logic [7:0] byte_of(input logic [127:0] v, input logic [3:0] i);
        byte_of = v[8*(15-i) +: 8];
    endfunction : byte_of

    function automatic logic [15:0] entries_bytes(input logic [5:0] n);
        entries_bytes = {6'h00, 7'({1'b0, n} + 7'h01), 3'h0};
    endfunction : entries_bytes

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++) begin
            r = r[15] ? ((r << 1) ^ `TMF_CRC_POLY) : (r << 1);
        end
        crc_byte = r;
    endfunction : crc_byte

    fr_state_t      st_q, st_d;
    frame_cfg_t     cfg_q;
    emission_time_t time_mem [64];
    station_entry_t stn_mem  [64];
    logic [15:0]    mtu_q;
    logic [7:0]     port_off_q;
    logic           sign_en_q;
    logic [31:0]    ext_q;
    logic           sign_q;
    logic [15:0]    dport_q;
    logic [15:0]    cap_q;
    logic [31:0]    ts_q;
    logic [3:0]     hcnt_q, hcnt_d;
    logic [15:0]    pidx_q, pidx_d;
    logic [15:0]    pcnt_q, pcnt_d;
    logic [15:0]    seq_q, seq_d;
    logic           first_q, first_d;
    logic [15:0]    crc_q, crc_d;
    logic           oval_q, oval_d;
    logic [7:0]     odat_q, odat_d;
    logic           olast_q, olast_d;
    pkt_info_t      info_q, info_d;
    logic [31:0]    rdata_q;

    // Decode
    wire            idle      = (st_q == ST_IDLE);
    wire            adv       = !oval_q || out_ready;
    wire            start_ok  = idle && frame_start;
    wire [15:0]     tim_end   = `TMF_STRUCT_HDR + entries_bytes(cfg_q.emis_cnt_m1);
    wire [15:0]     tx_end    = tim_end + entries_bytes(cfg_q.group_size_m1);
    wire [15:0]     s_len     = tx_end + `TMF_TAIL_BYTES;
    wire [15:0]     off_t     = pidx_q - `TMF_STRUCT_HDR;
    wire [15:0]     off_x     = pidx_q - tim_end;
    wire [15:0]     off_z     = pidx_q - tx_end;
    wire            in_hdr    = pidx_q < `TMF_STRUCT_HDR;
    wire            in_tim    = pidx_q < tim_end;
    wire            in_stn    = pidx_q < tx_end;
    wire            in_crc    = !in_stn && off_z[1];
    wire            s_end     = (pidx_q == s_len - 16'h0001);
    wire            p_full    = (pcnt_q == cap_q - 16'h0001);
    wire [3:0]      hdr_last  = sign_q ? `TMF_HDR_LAST_EXT : `TMF_HDR_LAST;
    wire [15:0]     cap_new   = mtu_q - `TMF_IP_UDP_BYTES - `TMF_RTP_BYTES
                                - (sign_en_q ? `TMF_EXT_BYTES : 16'h0000);

    // Structure header, MSB first
    wire [95:0]     hdr_vec   = {s_len, `TMF_VER_MAJOR, `TMF_VER_MINOR,
                                 cfg_q.rep_pre, cfg_q.rep_tim,
                                 cfg_q.bs_major, cfg_q.bs_minor,
                                 cfg_q.min_frame_gap_code, cfg_q.bandwidth,
                                 cfg_q.bsr_coef, cfg_q.preamble_layout,
                                 cfg_q.alert_wakeup_bits, cfg_q.emis_cnt_m1,
                                 cfg_q.group_size_m1, cfg_q.group_num,
                                 cfg_q.override_code, cfg_q.filt_code_cnt,
                                 cfg_q.carrier_offset, `TMF_RSV6};
    // Loop entries
    wire emission_time_t tw   = time_mem[off_t[8:3]];
    wire station_entry_t sw   = stn_mem[off_x[8:3]];
    wire [63:0]     stn_vec   = {sw.station_identifier, sw.time_offset,
                                 sw.inject_lvl, sw.filt_idx, `TMF_RSV29};
    // Release time and check word
    wire [31:0]     tail_vec  = {cfg_q.rls_seconds, cfg_q.rls_subsec, `TMF_RSV2, crc_q};
    wire [7:0]      body_byte = in_hdr ? byte_of({hdr_vec, 32'h0}, pidx_q[3:0]) :
                                in_tim ? byte_of({tw, 64'h0}, {1'b0, off_t[2:0]}) :
                                in_stn ? byte_of({stn_vec, 64'h0}, {1'b0, off_x[2:0]}) :
                                byte_of({tail_vec, 96'h0}, {2'b00, off_z[1:0]});

    // RTP header: P, CC zero, X per signing, fixed PT, zero SSRC
    wire [127:0]    rtp_vec   = {`TMF_RTP_VER, 1'b0, sign_q, 4'h0,
                                 first_q, `TMF_PAYLOAD_TYPE,
                                 seq_q, ts_q, `TMF_SSRC,
                                 ext_q};
    wire [7:0]      rtp_byte  = byte_of(rtp_vec, hcnt_q);

    // Register read mux
    wire [31:0]     rd_mux    = (reg_addr == `TMF_REG_CTRL)   ? {23'h0, sign_en_q, port_off_q} :
                                (reg_addr == `TMF_REG_EXT)    ? ext_q :
                                (reg_addr == `TMF_REG_STATUS) ? {15'h0, !idle, seq_q} :
                                (reg_addr == `TMF_REG_MTU)    ? {16'h0, mtu_q} : 32'h0;

    always_comb begin
        st_d    = st_q;
        hcnt_d  = hcnt_q;
        pidx_d  = pidx_q;
        pcnt_d  = pcnt_q;
        seq_d   = seq_q;
        first_d = first_q;
        crc_d   = crc_q;
        oval_d  = oval_q && !out_ready;
        odat_d  = odat_q;
        olast_d = olast_q;
        info_d  = info_q;
        case (st_q)
            ST_IDLE: begin
                if (frame_start) begin
                    st_d    = ST_HDR;
                    hcnt_d  = 4'h0;
                    pidx_d  = 16'h0000;
                    pcnt_d  = 16'h0000;
                    first_d = 1'b1;
                    crc_d   = `TMF_CRC_INIT;
                end
            end
            ST_HDR: begin
                if (adv) begin
                    oval_d  = 1'b1;
                    odat_d  = rtp_byte;
                    olast_d = 1'b0;
                    hcnt_d  = hcnt_q + 4'h1;
                    if (hcnt_q == 4'h0) begin
                        info_d = '{dst_ip: `TMF_MCAST_IP, dst_port: dport_q,
                                   marker: first_q};
                    end
                    if (hcnt_q == hdr_last) begin
                        st_d   = ST_BODY;
                        pcnt_d = 16'h0000;
                    end
                end
            end
            ST_BODY: begin
                if (adv) begin
                    oval_d  = 1'b1;
                    odat_d  = body_byte;
                    olast_d = s_end || p_full;
                    pidx_d  = pidx_q + 16'h0001;
                    pcnt_d  = pcnt_q + 16'h0001;
                    if (!in_crc) begin
                        crc_d = crc_byte(crc_q, body_byte);
                    end
                    if (s_end || p_full) begin
                        seq_d   = seq_q + 16'h0001;
                        first_d = 1'b0;
                        hcnt_d  = 4'h0;
                        st_d    = s_end ? ST_IDLE : ST_HDR;
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Tables are frozen while a set is on the wire so every fragment agrees
    always_ff @(posedge mclk) begin
        if (time_wr && idle) begin
            time_mem[time_idx] <= time_data;
        end
        if (stn_wr && idle) begin
            stn_mem[stn_idx] <= stn_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mtu_q      <= `TMF_MTU_RESET;
            port_off_q <= 8'h00;
            sign_en_q  <= 1'b0;
            ext_q      <= 32'h0;
            rdata_q    <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `TMF_REG_CTRL) begin
                port_off_q <= reg_wdata[7:0];
                sign_en_q  <= reg_wdata[8];
            end
            if (reg_wr && reg_addr == `TMF_REG_EXT) begin
                ext_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `TMF_REG_MTU) begin
                mtu_q <= reg_wdata[15:0];
            end
            rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // Per-set values latched once at the start
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg_q   <= '0;
            sign_q  <= 1'b0;
            dport_q <= `TMF_UDP_PORT;
            cap_q   <= 16'h0001;
            ts_q    <= 32'h0;
        end else if (start_ok) begin
            cfg_q   <= frame_cfg;
            sign_q  <= sign_en_q;
            dport_q <= `TMF_UDP_PORT + {8'h00, port_off_q};
            cap_q   <= cap_new;
            ts_q    <= {time_mem[0].seconds[21:0], time_mem[0].nanoseconds[29:20]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q    <= ST_IDLE;
            hcnt_q  <= 4'h0;
            pidx_q  <= 16'h0000;
            pcnt_q  <= 16'h0000;
            seq_q   <= 16'h0000;
            first_q <= 1'b0;
            crc_q   <= `TMF_CRC_INIT;
            oval_q  <= 1'b0;
            odat_q  <= 8'h00;
            olast_q <= 1'b0;
            info_q  <= '0;
        end else begin
            st_q    <= st_d;
            hcnt_q  <= hcnt_d;
            pidx_q  <= pidx_d;
            pcnt_q  <= pcnt_d;
            seq_q   <= seq_d;
            first_q <= first_d;
            crc_q   <= crc_d;
            oval_q  <= oval_d;
            odat_q  <= odat_d;
            olast_q <= olast_d;
            info_q  <= info_d;
        end
    end

    assign frame_ready = idle;
    assign out_valid   = oval_q;
    assign out_data    = odat_q;
    assign out_last    = olast_q;
    assign out_info    = info_q;
    assign reg_rdata   = rdata_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    wire hdr_emit  = (st_q == ST_HDR) && adv;
    wire body_emit = (st_q == ST_BODY) && adv;

    a_dest_group: assert property (out_valid |-> out_info.dst_ip == `TMF_MCAST_IP)
        else $error("destination group wrong");
    a_pkt_fits: assert property ((st_q == ST_BODY) |-> pcnt_q < cap_q)
        else $error("packet exceeds payload capacity");
    a_marker_cont: assert property (hdr_emit && hcnt_q == 4'h1 && pidx_q != 16'h0
        |=> !out_info.marker && out_data[7] == 1'b0)
        else $error("continuation packet carries marker");
    a_marker_first: assert property (hdr_emit && hcnt_q == 4'h1 && pidx_q == 16'h0
        |=> out_info.marker && out_data[7])
        else $error("first packet lacks marker");
    a_ts_stable: assert property (!idle && !start_ok |=> $stable(ts_q))
        else $error("timestamp changed within a set");
    a_pad_zero: assert property (hdr_emit && hcnt_q == 4'h0 |=> out_data[5] == 1'b0)
        else $error("padding bit set");
    a_ext_bit: assert property (hdr_emit && hcnt_q == 4'h0 |=> out_data[4] == sign_q)
        else $error("extension bit disagrees with signing");
    a_ext_word: assert property (hdr_emit && hcnt_q == 4'hC |=> out_data == ext_q[31:24])
        else $error("extension word misplaced");
    a_csrc_none: assert property (hdr_emit && hcnt_q == 4'h0 |=> out_data[3:0] == 4'h0)
        else $error("contributing source count nonzero");
    a_pt_value: assert property (hdr_emit && hcnt_q == 4'h1 |=> out_data[6:0] == `TMF_PAYLOAD_TYPE)
        else $error("payload type wrong");
    a_seq_step: assert property (body_emit && (s_end || p_full)
        |=> seq_q == $past(seq_q) + 16'h0001)
        else $error("sequence did not advance by one");
    a_ssrc_zero: assert property (hdr_emit && hcnt_q >= 4'h8 && hcnt_q <= 4'hB
        |=> out_data == 8'h00)
        else $error("source identifier nonzero");
    a_version_zero: assert property (body_emit && pidx_q == 16'h0002 |=> out_data == 8'h00)
        else $error("version fields nonzero");
    a_hdr_reserved: assert property (body_emit && pidx_q == 16'h000B
        |=> out_data[5:0] == `TMF_RSV6)
        else $error("header reserved bits not ones");
    a_len_high: assert property (body_emit && pidx_q == 16'h0000
        |=> out_data == $past(s_len[15:8]))
        else $error("length field wrong");

    c_multi_pkt: cover property (body_emit && p_full && !s_end);
    c_signed_set: cover property (hdr_emit && sign_q && hcnt_q == 4'hF);
    c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
    c_set_done: cover property (body_emit && s_end);

endmodule : timing_mgmt_rtp_framer
`default_nettype wire

// file: logic/tmf_consts.svh
// Constants for the timing and management packet framer
`ifndef TMF_CONSTS_SVH
`define TMF_CONSTS_SVH
`define TMF_MCAST_IP      32'hEF003330
`define TMF_UDP_PORT      16'h7571
`define TMF_RTP_VER       2'h2
`define TMF_PAYLOAD_TYPE  7'h4C
`define TMF_SSRC          32'h00000000
`define TMF_VER_MAJOR     4'h0
`define TMF_VER_MINOR     4'h0
`define TMF_MTU_RESET     16'h05DC
`define TMF_IP_UDP_BYTES  16'h001C
`define TMF_RTP_BYTES     16'h000C
`define TMF_EXT_BYTES     16'h0004
`define TMF_HDR_LAST      4'hB
`define TMF_HDR_LAST_EXT  4'hF
`define TMF_STRUCT_HDR    16'h000C
`define TMF_TAIL_BYTES    16'h0004
`define TMF_RSV6          6'h3F
`define TMF_RSV29         29'h1FFFFFFF
`define TMF_RSV2          2'h3
`define TMF_CRC_POLY      16'h1021
`define TMF_CRC_INIT      16'hFFFF
`define TMF_REG_CTRL      4'h0
`define TMF_REG_EXT       4'h4
`define TMF_REG_STATUS    4'h8
`define TMF_REG_MTU       4'hC
`endif

// file: logic/tmf_pkg.sv
// Types for the timing and management packet framer
`default_nettype none
package tmf_pkg;
    typedef struct packed {
        logic [3:0] rep_pre;
        logic [3:0] rep_tim;
        logic [3:0] bs_major;
        logic [3:0] bs_minor;
        logic [4:0] min_frame_gap_code;
        logic [1:0] bandwidth;
        logic [6:0] bsr_coef;
        logic [7:0] preamble_layout;
        logic [1:0] alert_wakeup_bits;
        logic [5:0] emis_cnt_m1;
        logic [5:0] group_size_m1;
        logic [6:0] group_num;
        logic [2:0] override_code;
        logic [1:0] filt_code_cnt;
        logic [1:0] carrier_offset;
        logic [3:0] rls_seconds;
        logic [9:0] rls_subsec;
    } frame_cfg_t;

    typedef struct packed {
        logic [31:0] seconds;
        logic [31:0] nanoseconds;
    } emission_time_t;

    typedef struct packed {
        logic [12:0] station_identifier;
        logic [15:0] time_offset;
        logic [3:0]  inject_lvl;
        logic [1:0]  filt_idx;
    } station_entry_t;

    typedef struct packed {
        logic [31:0] dst_ip;
        logic [15:0] dst_port;
        logic        marker;
    } pkt_info_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HDR  = 3'b010,
        ST_BODY = 3'b100
    } fr_state_t;
endpackage : tmf_pkg
`default_nettype wire

// file: verification/tmf_sink_model.sv
// Receiver-side sink model: accepts the byte stream and rebuilds the payload structure
`timescale 1ns/10ps
`default_nettype none
module tmf_sink_model
    import tmf_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Stall control
    input  wire logic       slow,
    // Byte stream
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    input  wire pkt_info_t  out_info,
    output logic            out_ready
);
    logic [7:0]  pkt_q[$];
    logic [7:0]  byte_q[$];
    logic [7:0]  rx_struct[$];
    int          plen_q[$];
    pkt_info_t   info_q[$];
    int          n_sets = 0;
    logic [15:0] last_seq = 16'h0000;
    logic        collecting = 1'b0;
    logic [1:0]  phase = 2'h0;

    // Stalls one cycle in four so the framer must hold its byte
    always @(posedge mclk) begin
        phase <= phase + 2'h1;
        out_ready <= resetn && !(slow && phase == 2'h0);
    end

    always @(posedge mclk) begin
        if (resetn && out_valid && out_ready) begin
            pkt_q.push_back(out_data);
            byte_q.push_back(out_data);
            if (out_last) begin
                take_packet();
                pkt_q.delete();
            end
        end
    end

    // Arrival is in order here, so reordering reduces to checking the sequence
    task automatic take_packet();
        int          hl;
        logic [15:0] sq;
        hl = pkt_q[0][4] ? 16 : 12;
        sq = {pkt_q[2], pkt_q[3]};
        plen_q.push_back(pkt_q.size());
        info_q.push_back(out_info);
        if (pkt_q[1][7]) begin
            rx_struct.delete();
            collecting = 1'b1;
        end else if (sq != last_seq + 16'h0001) begin
            collecting = 1'b0;
        end
        last_seq = sq;
        if (collecting) begin
            for (int i = hl; i < pkt_q.size(); i++) rx_struct.push_back(pkt_q[i]);
            if (rx_struct.size() >= 2 && rx_struct.size() >= {rx_struct[0], rx_struct[1]}) begin
                collecting = 1'b0;
                n_sets++;
            end
        end
    endtask : take_packet
endmodule : tmf_sink_model
`default_nettype wire

// file: verification/timing_mgmt_rtp_framer_tb.sv
// Self-checking bench for the timing and management packet framer
`timescale 1ns/10ps
`default_nettype none
module timing_mgmt_rtp_framer_tb
    import tmf_pkg::*;
;
    logic           mclk, resetn = 1'b0, slow = 1'b0;
    logic [3:0]     reg_addr = 4'h0;
    logic [31:0]    reg_wdata = 32'h0, reg_rdata;
    logic           reg_wr = 1'b0, reg_rd = 1'b0, frame_start = 1'b0, frame_ready;
    frame_cfg_t     frame_cfg = '0;
    logic           time_wr = 1'b0, stn_wr = 1'b0;
    logic [5:0]     time_idx = 6'h0, stn_idx = 6'h0;
    emission_time_t time_data = '0;
    station_entry_t stn_data = '0;
    logic           out_valid, out_last, out_ready;
    logic [7:0]     out_data;
    pkt_info_t      out_info;
    int             n_errors = 0, comparisons = 0, bidx = 0, pidx = 0;
    logic [15:0]    seq_exp = 16'h0;
    logic [7:0]     exp_s[$];

    timing_mgmt_rtp_framer dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .frame_start, .frame_cfg, .frame_ready, .time_wr, .time_idx, .time_data,
        .stn_wr, .stn_idx, .stn_data, .out_valid, .out_data, .out_last, .out_info, .out_ready);
    tmf_sink_model snk (.mclk, .resetn, .slow, .out_valid, .out_data, .out_last, .out_info,
        .out_ready);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Counts: comparisons=%0d mismatches=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd_chk

    task automatic wait_ready();
        int w;
        w = 0;
        while (frame_ready !== 1'b1 && w < 20000) begin
            @(posedge mclk);
            #1 w++;
        end
        if (w == 20000) begin
            n_errors++;
            report_and_stop();
        end
    endtask : wait_ready

    function automatic emission_time_t tim(input int i, input int k);
        return '{32'h9ABCDEF0 ^ 32'(i * 17 + k), 32'h2F5A3C00 ^ (32'(i + k) << 20)};
    endfunction : tim

    function automatic station_entry_t stn(input int i);
        return '{13'h1ABC ^ 13'(i), 16'h8001 + 16'(i), 4'(i), 2'(i)};
    endfunction : stn

    function automatic logic [31:0] w32(input int b);
        return {snk.byte_q[b], snk.byte_q[b + 1], snk.byte_q[b + 2], snk.byte_q[b + 3]};
    endfunction : w32

    task automatic push_w(input logic [95:0] v, input int n);
        for (int j = n - 1; j >= 0; j--) exp_s.push_back(v[8 * j +: 8]);
    endtask : push_w

    task automatic run_frame(input int k, input int e, input int g, input logic sgn,
                             input logic [7:0] off, input int mtu);
        frame_cfg_t     c;
        int             len, hl, cap, npk, plen, b, sets, w;
        logic [15:0]    crc;
        emission_time_t t0;
        c = frame_cfg_t'(80'hA5C3_96F0_1E2D_4B78_6C59 ^ 80'(k));
        c.emis_cnt_m1 = 6'(e);
        c.group_size_m1 = 6'(g);
        len = 12 + 8 * (e + 1) + 8 * (g + 1) + 4;
        hl = sgn ? 16 : 12;
        cap = mtu - 28 - hl;
        npk = (len + cap - 1) / cap;
        for (int i = 0; i < 64; i++) begin
            @(posedge mclk);
            time_wr <= 1'b1;
            time_idx <= 6'(i);
            time_data <= tim(i, k);
            stn_wr <= 1'b1;
            stn_idx <= 6'(i);
            stn_data <= stn(i);
        end
        @(posedge mclk);
        time_wr <= 1'b0;
        stn_wr <= 1'b0;
        reg_write(4'h0, {23'h0, sgn, off});
        reg_write(4'h4, 32'hC0DE0000 + 32'(k));
        reg_write(4'hC, 32'(mtu));
        rd_chk(4'h0, {23'h0, sgn, off});
        rd_chk(4'h4, 32'hC0DE0000 + 32'(k));
        rd_chk(4'hC, 32'(mtu));
        exp_s.delete();
        push_w({16'(len), 8'h00, c.rep_pre, c.rep_tim, c.bs_major, c.bs_minor,
            c.min_frame_gap_code, c.bandwidth, c.bsr_coef, c.preamble_layout, c.alert_wakeup_bits,
            c.emis_cnt_m1, c.group_size_m1, c.group_num, c.override_code, c.filt_code_cnt,
            c.carrier_offset, 6'h3F}, 12);
        for (int i = 0; i <= e; i++) push_w(96'(tim(i, k)), 8);
        for (int i = 0; i <= g; i++) push_w(96'({stn(i), 29'h1FFFFFFF}), 8);
        push_w(96'({c.rls_seconds, c.rls_subsec, 2'h3}), 2);
        crc = 16'hFFFF;
        foreach (exp_s[i]) begin
            crc = crc ^ {exp_s[i], 8'h00};
            repeat (8) crc = crc[15] ? ((crc << 1) ^ 16'h1021) : (crc << 1);
        end
        push_w(96'(crc), 2);
        sets = snk.n_sets;
        @(posedge mclk);
        frame_start <= 1'b1;
        frame_cfg <= c;
        @(posedge mclk);
        frame_start <= 1'b0;
        #1 chk(frame_ready, 1'b0);
        // A start while busy must be ignored; the packet totals below would show it
        @(posedge mclk);
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        // Still inside the first packet here, so the next sequence number is unchanged
        rd_chk(4'h8, {15'h0, 1'b1, seq_exp});
        w = 0;
        while (snk.n_sets == sets && w < 20000) begin
            @(posedge mclk);
            w++;
        end
        if (w == 20000) begin
            n_errors++;
            report_and_stop();
        end
        wait_ready();
        t0 = tim(0, k);
        for (int p = 0; p < npk; p++) begin
            b = bidx;
            plen = (p == npk - 1) ? len - cap * (npk - 1) : cap;
            chk(snk.plen_q[pidx], hl + plen);
            chk(w32(b), {(sgn ? 8'h90 : 8'h80), (p == 0), 7'h4C, seq_exp});
            chk(w32(b + 4), {t0.seconds[21:0], t0.nanoseconds[29:20]});
            chk(w32(b + 8), 32'h0);
            if (sgn) chk(w32(b + 12), 32'hC0DE0000 + 32'(k));
            chk(snk.info_q[pidx].dst_ip, 32'hEF003330);
            chk(snk.info_q[pidx].dst_port, 16'h7571 + {8'h00, off});
            chk(snk.info_q[pidx].marker, (p == 0));
            bidx = b + hl + plen;
            pidx++;
            seq_exp++;
        end
        chk(snk.rx_struct.size(), len);
        foreach (exp_s[i]) chk(snk.rx_struct[i], exp_s[i]);
        $display("Test %0d done", k);
    endtask : run_frame

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(4'hC, 32'h000005DC);
        rd_chk(4'h0, 32'h0);
        rd_chk(4'h8, 32'h0);
        rd_chk(4'h2, 32'h0);
        $display("Test 0 done");
        slow <= 1'b1;
        run_frame(1, 3, 5, 1'b0, 8'h00, 80);
        slow <= 1'b0;
        run_frame(2, 0, 0, 1'b1, 8'h03, 60);
        slow <= 1'b1;
        run_frame(3, 63, 63, 1'b0, 8'hFF, 1500);
        repeat (20) @(posedge mclk);
        chk(snk.plen_q.size(), 6);
        rd_chk(4'h8, 32'h00000006);
        report_and_stop();
    end
endmodule : timing_mgmt_rtp_framer_tb
`default_nettype wire
